/* File: logic/adc_conversion_data_port.sv */
// converter control and parallel data port
//
// Overview of operation
// - from the external clock each conversion takes fourteen periods before its strobe
// - results sit on a 12-bit bus, bit 11 most significant
// - coding is two's complement when bipolar, straight binary when unipolar
// - low four lines drive on read, act as inputs on a write
// - mask bit 0 selects channel 1 up to bit 3 for channel 4
// - end-of-conversion output pulses low once per channel conversion
// - lines 4 to 11 are outputs driven only during a read
// - start rising edge holds all inputs, latches sequence, begins converting
// - mask captures low lines on write rising edge with select low, read high
// - selector high uses the mask register, low uses the hardware pins
// - clock selector high uses external clock, low the internal oscillator
`timescale 1ns/1ps
`include "adc_port_defs.svh"
module adc_conversion_data_port #(
	parameter bit         BIPOLAR     = 1'b1,
	parameter logic [7:0] INT_CLK_DIV = `INT_CLK_DIV,
	parameter int         FIFO_DEPTH  = `FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                        clock,
	input  wire logic                        rst,
	// conversion control pins
	input  wire logic                        sample_start_n,
	input  wire logic                        clock_source_select,
	input  wire logic                        ext_conversion_clock,
	input  wire logic                        hw_sw_select,
	input  wire logic [3:0]                  hw_channel_pins,
	// host strobes
	input  wire logic                        chip_select_n,
	input  wire logic                        read_n,
	input  wire logic                        write_n,
	// raw offset-binary codes from the converter core
	input  wire logic [3:0][11:0]            core_codes,
	// data bus
	output logic [5:0]                       result_bus_high,
	output logic                             result_bus_high_oe,
	output logic [1:0]                       result_bus_mid,
	output logic                             result_bus_mid_oe,
	output logic [3:0]                       result_bus_low_out,
	output logic                             result_bus_low_oe,
	input  wire logic [3:0]                  result_bus_low_in,
	// status
	output logic                             eoc_n,
	output logic                             busy
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	adc_types_pkg::pin_in_type pins_raw;
	adc_types_pkg::pin_in_type sync1_ff;
	adc_types_pkg::pin_in_type sync2_ff;
	adc_types_pkg::pin_in_type prev_ff;

	assign pins_raw = '{sample_start_n, chip_select_n, read_n, write_n, hw_sw_select,
		clock_source_select, ext_conversion_clock, result_bus_low_in, hw_channel_pins};

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			// start pin idles high, so no false start edge after reset
			sync1_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0};
			sync2_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0};
			prev_ff  <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0};
		end
		else
		begin
			sync1_ff <= pins_raw;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	logic start_edge;
	logic write_edge;
	logic read_active;
	logic read_start;
	logic ext_tick;

	assign start_edge  = sync2_ff.sample_start_n && !prev_ff.sample_start_n;
	assign write_edge  = sync2_ff.write_n && !prev_ff.write_n && !sync2_ff.chip_select_n
		&& sync2_ff.read_n;
	assign read_active = !sync2_ff.chip_select_n && !sync2_ff.read_n && sync2_ff.write_n;
	assign read_start  = read_active
		&& !(!prev_ff.chip_select_n && !prev_ff.read_n && prev_ff.write_n);
	assign ext_tick    = sync2_ff.ext_conversion_clock && !prev_ff.ext_conversion_clock;

	// ------------------------------------------------------------
	// conversion clock source
	// ------------------------------------------------------------
	logic [7:0] int_div_ff;
	logic       int_tick;
	logic       conv_tick;

	always_ff @(posedge clock)
	begin
		if (rst)
			int_div_ff <= 8'h00;
		else if (int_div_ff == INT_CLK_DIV - 8'h01)
			int_div_ff <= 8'h00;
		else
			int_div_ff <= int_div_ff + 8'h01;
	end

	assign int_tick  = (int_div_ff == INT_CLK_DIV - 8'h01);
	assign conv_tick = sync2_ff.clock_source_select ? ext_tick : int_tick;

	// ------------------------------------------------------------
	// channel enable register
	// ------------------------------------------------------------
	logic [3:0] channel_enable_mask_ff;

	always_ff @(posedge clock)
	begin
		if (rst)
			channel_enable_mask_ff <= `CHAN_MASK_RESET;
		else if (write_edge)
			channel_enable_mask_ff <= sync2_ff.result_bus_low_in;
	end

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	adc_types_pkg::conv_state_type state_ff;
	adc_types_pkg::conv_state_type nxt_state;
	logic [3:0]       sel_mask;
	logic [3:0]       pending_ff;
	logic [3:0]       tick_cnt_ff;
	logic [3:0]       eoc_cnt_ff;
	logic [3:0][11:0] held_ff;
	logic [1:0]       cur_chan;
	logic             eoc_n_ff;
	logic             busy_ff;
	logic             fifo_in_ready;
	logic             fifo_out_valid;
	adc_types_pkg::result_word_type push_word;
	adc_types_pkg::result_word_type fifo_word;

	// lowest pending channel, bit 0 being channel 1
	function automatic logic [1:0] lowest_chan(input logic [3:0] m);
		lowest_chan = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
	endfunction

	function automatic logic [11:0] encode(input logic [11:0] raw);
		encode = BIPOLAR ? {~raw[`RESULT_MSB], raw[`RESULT_MSB-1:0]} : raw;
	endfunction

	assign sel_mask = sync2_ff.hw_sw_select ? channel_enable_mask_ff
		: sync2_ff.hw_channel_pins;
	assign cur_chan = lowest_chan(pending_ff);

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			adc_types_pkg::ST_IDLE:
				if (start_edge && sel_mask != 4'h0)
					nxt_state = adc_types_pkg::ST_CONVERT;
			adc_types_pkg::ST_CONVERT:
				if (conv_tick && tick_cnt_ff == `CONV_CLK_PERIODS - 4'h1)
					nxt_state = adc_types_pkg::ST_PUSH;
			adc_types_pkg::ST_PUSH:
				if (fifo_in_ready)
					nxt_state = adc_types_pkg::ST_EOC;
			adc_types_pkg::ST_EOC:
				if (eoc_cnt_ff == 4'(`EOC_PULSE_CYC - 1))
					nxt_state = (pending_ff != 4'h0) ? adc_types_pkg::ST_CONVERT
						: adc_types_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			state_ff <= adc_types_pkg::ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// hold all four inputs and latch the sequence on the start edge
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pending_ff <= 4'h0;
			held_ff    <= '0;
		end
		else if (state_ff == adc_types_pkg::ST_IDLE && start_edge)
		begin
			pending_ff <= sel_mask;
			held_ff    <= core_codes;
		end
		else if (state_ff == adc_types_pkg::ST_PUSH && fifo_in_ready)
			pending_ff[cur_chan] <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (rst || state_ff != adc_types_pkg::ST_CONVERT)
			tick_cnt_ff <= 4'h0;
		else if (conv_tick)
			tick_cnt_ff <= tick_cnt_ff + 4'h1;
	end

	always_ff @(posedge clock)
	begin
		if (rst || state_ff != adc_types_pkg::ST_EOC)
			eoc_cnt_ff <= 4'h0;
		else
			eoc_cnt_ff <= eoc_cnt_ff + 4'h1;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			eoc_n_ff <= 1'b1;
			busy_ff  <= 1'b0;
		end
		else
		begin
			eoc_n_ff <= (nxt_state != adc_types_pkg::ST_EOC);
			busy_ff  <= (nxt_state != adc_types_pkg::ST_IDLE);
		end
	end

	assign eoc_n = eoc_n_ff;
	assign busy  = busy_ff;

	// ------------------------------------------------------------
	// result buffer and read path
	// ------------------------------------------------------------
	assign push_word.channel = cur_chan;
	assign push_word.code    = encode(held_ff[cur_chan]);

	result_fifo #(
		.WIDTH ($bits(adc_types_pkg::result_word_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (state_ff == adc_types_pkg::ST_PUSH),
		.in_ready  (fifo_in_ready),
		.in_data   (push_word),
		.out_valid (fifo_out_valid),
		.out_ready (read_start),
		.out_data  (fifo_word)
	);

	logic [11:0] data_ff;

	always_ff @(posedge clock)
	begin
		if (rst)
			data_ff <= 12'h000;
		else if (read_start && fifo_out_valid)
			data_ff <= fifo_word.code;
	end

	assign result_bus_high    = data_ff[`RESULT_MSB:`HIGH_BUS_LSB];
	assign result_bus_mid     = data_ff[`HIGH_BUS_LSB-1:`MID_BUS_LSB];
	assign result_bus_low_out = data_ff[`MID_BUS_LSB-1:0];
	assign result_bus_high_oe = read_active;
	assign result_bus_mid_oe  = read_active;
	assign result_bus_low_oe  = read_active;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking dcb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_eoc_low;
		$fell(eoc_n) ##0 (!eoc_n)[*2] ##1 eoc_n;
	endsequence

	sequence s_seq_start;
		state_ff == adc_types_pkg::ST_IDLE && start_edge && sel_mask != 4'h0;
	endsequence

	a_conv_length: assert property (
		state_ff == adc_types_pkg::ST_CONVERT ##1 state_ff == adc_types_pkg::ST_PUSH
		|-> $past(tick_cnt_ff) == 4'hD && $past(conv_tick))
		else $error("conversion left before fourteen clock periods");

	a_result_order: assert property (
		read_start && fifo_out_valid |=> result_bus_high[5] == data_ff[11]
		&& result_bus_low_out[0] == data_ff[0] && data_ff == $past(fifo_word.code))
		else $error("result bus order or content wrong");

	a_coding_msb: assert property (
		state_ff == adc_types_pkg::ST_PUSH
		|-> push_word.code[11] == (BIPOLAR ^ held_ff[cur_chan][11]))
		else $error("result coding does not match variant");

	a_low_bus_dir: assert property (
		result_bus_low_oe |-> !sync2_ff.chip_select_n && !sync2_ff.read_n && sync2_ff.write_n)
		else $error("low bus driven outside a read");

	a_chan_mask_map: assert property (
		state_ff == adc_types_pkg::ST_PUSH |-> pending_ff[cur_chan]
		&& (cur_chan == 2'h0 || pending_ff[0] == 1'b0))
		else $error("channel order or mask bit mapping wrong");

	a_eoc_pulse: assert property (
		state_ff == adc_types_pkg::ST_PUSH && fifo_in_ready |=> s_eoc_low)
		else $error("end-of-conversion pulse missing or wrong width");

	a_high_bus_tristate: assert property (
		!read_active |-> !result_bus_high_oe && !result_bus_mid_oe)
		else $error("upper bus driven without a read");

	a_start_latch: assert property (
		s_seq_start |=> busy && pending_ff == $past(sel_mask) && held_ff == $past(core_codes))
		else $error("start edge did not latch sequence and samples");

	a_mask_write: assert property (
		write_edge |=> channel_enable_mask_ff == $past(sync2_ff.result_bus_low_in))
		else $error("channel enable mask not captured");

	a_seq_source: assert property (
		s_seq_start |=> pending_ff == ($past(sync2_ff.hw_sw_select)
		? $past(channel_enable_mask_ff) : $past(sync2_ff.hw_channel_pins)))
		else $error("sequence taken from wrong source");

	a_clk_source: assert property (
		state_ff == adc_types_pkg::ST_CONVERT && sync2_ff.clock_source_select && !ext_tick
		|=> tick_cnt_ff == $past(tick_cnt_ff) || state_ff != adc_types_pkg::ST_CONVERT)
		else $error("conversion advanced without external clock edge");

endmodule

/* File: logic/adc_port_defs.svh */
// constants for the converter control and data port
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS      40
`define EOC_PULSE_NS       80
`define EOC_PULSE_CYC      ((`EOC_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CLK_PERIODS   4'hE
`define INT_CLK_DIV        8'h03

// ------------------------------------------------------------
// field layout and reset values
// ------------------------------------------------------------
`define RESULT_WIDTH       12
`define RESULT_MSB         11
`define HIGH_BUS_LSB       6
`define MID_BUS_LSB        4
`define CHAN_COUNT         4
`define CHAN_MASK_RESET    4'hF
`define FIFO_DEPTH         8

`endif

/* File: logic/adc_types_pkg.sv */
// types shared by the converter port and its result buffer
package adc_types_pkg;

	// synchronised pin group
	typedef struct packed {
		logic       sample_start_n;
		logic       chip_select_n;
		logic       read_n;
		logic       write_n;
		logic       hw_sw_select;
		logic       clock_source_select;
		logic       ext_conversion_clock;
		logic [3:0] result_bus_low_in;
		logic [3:0] hw_channel_pins;
	} pin_in_type;

	// one buffered conversion result
	typedef struct packed {
		logic [1:0]  channel;
		logic [11:0] code;
	} result_word_type;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0001,
		ST_CONVERT = 4'b0010,
		ST_PUSH    = 4'b0100,
		ST_EOC     = 4'b1000
	} conv_state_type;

endpackage

/* File: logic/result_fifo.sv */
// result buffer with registered read data
`timescale 1ns/1ps
module result_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW-1:0]    wr_ptr_ff;
	logic [PW-1:0]    rd_ptr_ff;
	logic [CW-1:0]    count_ff;
	logic [WIDTH-1:0] out_data_ff;
	logic             out_valid_ff;
	logic             push;
	logic             pop;
	logic [PW-1:0]    nxt_rd_ptr;
	logic [CW-1:0]    nxt_count;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	assign in_ready   = (count_ff != CW'(DEPTH));
	assign push       = in_valid && in_ready;
	assign pop        = out_valid_ff && out_ready;
	assign nxt_rd_ptr = pop ? bump(rd_ptr_ff) : rd_ptr_ff;
	assign nxt_count  = count_ff + CW'(push) - CW'(pop);
	assign out_valid  = out_valid_ff;
	assign out_data   = out_data_ff;

	always_ff @(posedge clock)
	begin
		if (push)
			mem_ff[wr_ptr_ff] <= in_data;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wr_ptr_ff    <= '0;
			rd_ptr_ff    <= '0;
			count_ff     <= '0;
			out_valid_ff <= 1'b0;
			out_data_ff  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= bump(wr_ptr_ff);
			rd_ptr_ff    <= nxt_rd_ptr;
			count_ff     <= nxt_count;
			out_valid_ff <= (nxt_count != '0);
			// bypass so a word written to the head is seen at once
			out_data_ff  <= (push && wr_ptr_ff == nxt_rd_ptr) ? in_data : mem_ff[nxt_rd_ptr];
		end
	end

endmodule

/* File: testbench/adc_conversion_data_port_tb.sv */
// self-checking bench for the converter control and data port
`timescale 1ns/1ps
module adc_conversion_data_port_tb;
	logic             clock;
	logic             rst;
	logic             clock_source_select;
	logic             ext_conversion_clock;
	logic             hw_sw_select;
	logic [3:0]       hw_channel_pins;
	logic [3:0][11:0] codes;
	wire              cs_n, rd_n, wr_n, start_n, host_drive;
	wire  [3:0]       host_data;
	logic [5:0]       hi_a, hi_b;
	logic [1:0]       mid_a, mid_b;
	logic [3:0]       lo_a, lo_b, low_bus;
	logic             hoe_a, moe_a, loe_a, hoe_b, moe_b, loe_b;
	logic             eoc_n, busy, eoc_n_b, busy_b;
	logic             idle_pat, ext_run, eoc_prev, ext_prev, ok;
	logic [2:0]       ext_ph;
	logic [11:0]      w;
	int               fails, checks_done, eoc_cnt, edges, low_len;

	// level on the shared low lines: device, host, or a changing idle pattern
	assign low_bus = loe_a ? lo_a : (host_drive ? host_data : {4{idle_pat}});

	adc_conversion_data_port #(.BIPOLAR(1'b1)) DUT (.clock(clock), .rst(rst),
		.sample_start_n(start_n), .clock_source_select(clock_source_select),
		.ext_conversion_clock(ext_conversion_clock), .hw_sw_select(hw_sw_select),
		.hw_channel_pins(hw_channel_pins), .chip_select_n(cs_n), .read_n(rd_n),
		.write_n(wr_n), .core_codes(codes), .result_bus_high(hi_a),
		.result_bus_high_oe(hoe_a), .result_bus_mid(mid_a), .result_bus_mid_oe(moe_a),
		.result_bus_low_out(lo_a), .result_bus_low_oe(loe_a),
		.result_bus_low_in(low_bus), .eoc_n(eoc_n), .busy(busy));

	adc_conversion_data_port #(.BIPOLAR(1'b0)) DUT_uni (.clock(clock), .rst(rst),
		.sample_start_n(start_n), .clock_source_select(clock_source_select),
		.ext_conversion_clock(ext_conversion_clock), .hw_sw_select(hw_sw_select),
		.hw_channel_pins(hw_channel_pins), .chip_select_n(cs_n), .read_n(rd_n),
		.write_n(wr_n), .core_codes(codes), .result_bus_high(hi_b),
		.result_bus_high_oe(hoe_b), .result_bus_mid(mid_b), .result_bus_mid_oe(moe_b),
		.result_bus_low_out(lo_b), .result_bus_low_oe(loe_b),
		.result_bus_low_in(low_bus), .eoc_n(eoc_n_b), .busy(busy_b));

	host_port_model host (.clock(clock), .chip_select_n(cs_n), .read_n(rd_n),
		.write_n(wr_n), .sample_start_n(start_n), .host_drive(host_drive),
		.host_data(host_data), .bus_oe(hoe_a), .word_in({hi_a, mid_a, lo_a}));

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ---------------------------------------------------------
	// external clock, pattern and strobe monitor
	// ---------------------------------------------------------
	always @(posedge clock)
	begin
		#1;
		idle_pat = ~idle_pat;
		if (ext_run && busy === 1'b1)
			ext_ph = ext_ph + 3'd1;
		ext_conversion_clock = ext_ph[2];
	end

	always @(negedge clock)
	begin
		if (eoc_prev === 1'b1 && eoc_n === 1'b0)
		begin
			eoc_cnt++;
			if (clock_source_select)
				check(12'(edges), 12'd14, "conversion clock periods");
			edges = 0;
			low_len = 0;
		end
		if (eoc_n === 1'b0)
			low_len++;
		if (eoc_prev === 1'b0 && eoc_n === 1'b1)
			check(12'(low_len), 12'd2, "eoc pulse width");
		if (!ext_prev && ext_conversion_clock)
			edges++;
		eoc_prev = eoc_n;
		ext_prev = ext_conversion_clock;
	end

	// ---------------------------------------------------------
	// tasks
	// ---------------------------------------------------------
	task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic wrap_up();
		if (fails == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic bus_idle();
		check({9'd0, hoe_a, moe_a, loe_a}, 12'd0, "bus driven while idle");
	endtask

	task automatic read_chk(input int ch);
		host.read_word(w, ok);
		check({11'd0, ok}, 12'd1, "read not enabled");
		check(w, codes[ch] ^ 12'h800, "bipolar word");
		check({hi_b, mid_b, lo_b}, codes[ch], "unipolar word");
		bus_idle();
	endtask

	task automatic start_seq();
		eoc_cnt = 0;
		edges = 0;
		host.start_pulse();
		check({11'd0, busy}, 12'd1, "busy after start");
	endtask

	task automatic wait_idle(input int maxc, input logic [3:0] sel);
		for (int i = 0; i < maxc && busy !== 1'b0; i++)
			host.step(1);
		check({11'd0, busy}, 12'd0, "sequence did not end");
		check(12'(eoc_cnt), 12'($countones(sel)), "eoc pulses");
	endtask

	// ---------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------
	initial
	begin
		fails = 0;
		checks_done = 0;
		eoc_cnt = 0;
		edges = 0;
		low_len = 0;
		idle_pat = 1'b0;
		ext_run = 1'b1;
		ext_ph = 3'd0;
		eoc_prev = 1'b1;
		ext_prev = 1'b0;
		ext_conversion_clock = 1'b0;
		clock_source_select = 1'b1;
		hw_sw_select = 1'b1;
		hw_channel_pins = 4'h0;
		codes = {12'h07C, 12'h801, 12'h5A3, 12'hF0E};
		rst = 1'b1;
		repeat (6) @(posedge clock);
		#1;
		rst = 1'b0;
		host.step(4);
		check({10'd0, busy, eoc_n}, 12'd1, "reset outputs");
		bus_idle();
		host.write_mask(4'b0101, 1'b1);
		host.write_mask(4'b0010, 1'b0);
		start_seq();
		wait_idle(800, 4'b0101);
		read_chk(0);
		read_chk(2);
		ext_run = 1'b0;
		start_seq();
		host.step(150);
		check(12'(eoc_cnt), 12'd0, "converted without external clock");
		ext_run = 1'b1;
		wait_idle(800, 4'b0101);
		read_chk(0);
		read_chk(2);
		clock_source_select = 1'b0;
		hw_sw_select = 1'b0;
		hw_channel_pins = 4'b1000;
		start_seq();
		hw_channel_pins = 4'b1111;
		wait_idle(400, 4'b1000);
		read_chk(3);
		start_seq();
		wait_idle(400, 4'hF);
		start_seq();
		wait_idle(400, 4'hF);
		start_seq();
		host.step(300);
		check({busy, 11'(eoc_cnt)}, 12'h800, "full buffer must stall");
		for (int i = 0; i < 8; i++)
			read_chk(i % 4);
		wait_idle(400, 4'hF);
		for (int i = 0; i < 4; i++)
			read_chk(i);
		host.read_word(w, ok);
		check(w, codes[3] ^ 12'h800, "empty read keeps word");
		wrap_up();
	end

	initial
	begin
		#(40 * 20000);
		fails++;
		wrap_up();
	end
endmodule

/* File: testbench/host_port_model.sv */
// host side model: strobes, start pin and low bus lines
`timescale 1ns/1ps
module host_port_model (
	// clock
	input  wire logic        clock,
	// strobes and start
	output logic             chip_select_n,
	output logic             read_n,
	output logic             write_n,
	output logic             sample_start_n,
	// low bus lines
	output logic             host_drive,
	output logic [3:0]       host_data,
	// read side
	input  wire logic        bus_oe,
	input  wire logic [11:0] word_in
);
	initial
	begin
		chip_select_n = 1'b1;
		read_n = 1'b1;
		write_n = 1'b1;
		sample_start_n = 1'b1;
		host_drive = 1'b0;
		host_data = 4'h0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// sel low leaves the device deselected, so the write must be ignored
	task automatic write_mask(input logic [3:0] m, input logic sel);
		step(1);
		chip_select_n = ~sel;
		read_n = 1'b1;
		host_drive = 1'b1;
		host_data = m;
		write_n = 1'b0;
		step(3);
		write_n = 1'b1;
		step(3);
		chip_select_n = 1'b1;
		host_drive = 1'b0;
		step(3);
	endtask

	task automatic read_word(output logic [11:0] w, output logic ok);
		step(1);
		ok = 1'b0;
		chip_select_n = 1'b0;
		read_n = 1'b0;
		for (int i = 0; i < 10 && !ok; i++)
		begin
			step(1);
			ok = (bus_oe === 1'b1);
		end
		// word lands one edge after the enable
		step(2);
		w = word_in;
		chip_select_n = 1'b1;
		read_n = 1'b1;
		step(4);
	endtask

	task automatic start_pulse();
		step(1);
		sample_start_n = 1'b0;
		step(3);
		sample_start_n = 1'b1;
		// edge passes two synchroniser stages before busy rises
		step(3);
	endtask
endmodule
